// ---- src/sssp_pkg.sv ----
package sssp_pkg;

  // ****************************************************************
  // geometry
  // ****************************************************************
  localparam int ADDR_W     = 8;
  localparam int DATA_W     = 18;
  localparam int BURST_LEN  = 4;
  localparam int BURST_W    = 2;

  // ****************************************************************
  // pin encodings
  // ****************************************************************
  localparam logic ORDER_LINEAR      = 1'b0;
  localparam logic ORDER_INTERLEAVED = 1'b1;
  localparam logic RW_WRITE          = 1'b0;
  localparam logic RW_READ           = 1'b1;

  // ****************************************************************
  // timing: sleep entry and exit both act within one clock period
  // ****************************************************************
  localparam real CLOCK_PERIOD_NS            = 8.0;
  localparam real SLEEP_ENTRY_IGNORE_TIME_NS = 8.0;
  localparam real SLEEP_EXIT_SAMPLE_TIME_NS  = 8.0;
  localparam int  SLEEP_ENTRY_CYCLES =
    (int'($floor(SLEEP_ENTRY_IGNORE_TIME_NS / CLOCK_PERIOD_NS)) < 1) ? 1 :
    int'($floor(SLEEP_ENTRY_IGNORE_TIME_NS / CLOCK_PERIOD_NS));
  localparam int  SLEEP_EXIT_CYCLES =
    (int'($floor(SLEEP_EXIT_SAMPLE_TIME_NS / CLOCK_PERIOD_NS)) < 1) ? 1 :
    int'($floor(SLEEP_EXIT_SAMPLE_TIME_NS / CLOCK_PERIOD_NS));

  // ****************************************************************
  // carriers
  // ****************************************************************
  typedef struct packed {
    logic              chipSelectLowA;
    logic              chipSelectLowB;
    logic              chipSelectHigh;
    logic              advanceLoadN;
    logic              readWriteN;
    logic              burstOrder;
    logic [ADDR_W-1:0] addr;
  } sssp_cmd_s;

  typedef struct packed {
    logic              valid;
    logic              isWrite;
    logic              isBurst;
    logic              order;
    logic [ADDR_W-1:0] baseAddr;
    logic [BURST_W-1:0] count;
  } sssp_op_s;

  localparam sssp_op_s OP_IDLE = '0;

endpackage

// ---- src/sssp_sram.sv ----
`timescale 1ns/1ps
module sssp_sram #(
  parameter int ADDR_W = sssp_pkg::ADDR_W,
  parameter int DATA_W = sssp_pkg::DATA_W
) (
  input  wire logic              clk_sys,
  input  wire logic              rst,
  input  wire logic              sleepRequest,
  input  wire logic              clockEnableN,
  input  wire sssp_pkg::sssp_cmd_s cmd,
  input  wire logic [DATA_W-1:0] dataIn,
  output logic      [DATA_W-1:0] dataOut,
  output logic                   dataOutEnable,
  output logic                   asleep
);

  localparam int BW = sssp_pkg::BURST_W;

  // the command carrier fixes the address width, so only that one is served
  if (ADDR_W != sssp_pkg::ADDR_W || DATA_W < 1) begin : g_badWidth
    $error("sssp_sram: unsupported width");
  end
  if (sssp_pkg::BURST_LEN != 2 ** BW) begin : g_badBurst
    $error("sssp_sram: burst length must fill the count field");
  end

  // ****************************************************************
  // state
  // ****************************************************************
  logic [DATA_W-1:0]   mem [2**ADDR_W];
  sssp_pkg::sssp_op_s  stage1, next_stage1;
  sssp_pkg::sssp_op_s  stage2, next_stage2;
  logic [ADDR_W-1:0]   wrAddr, next_wrAddr;
  logic [DATA_W-1:0]   wrData, next_wrData;
  logic                wrPend, next_wrPend;
  logic [DATA_W-1:0]   next_dataOut;
  logic                next_dataOutEnable;
  logic                sleepSeen;
  logic                awake;
  logic                selected;
  logic                accept;
  logic                next_sleepSeen;
  logic [ADDR_W-1:0]   s2Addr;

  // sleep gates the inputs without a clock; dataOutEnable and asleep are registered,
  // so entry reaches both at the next clk_sys edge; exit reaches only asleep there, and dataOutEnable stays low
  assign awake    = !sleepRequest;
  assign selected = !cmd.chipSelectLowA && !cmd.chipSelectLowB
                    && cmd.chipSelectHigh;
  assign accept   = awake && !clockEnableN;

  // ****************************************************************
  // burst address of the access stage
  // ****************************************************************
  sssp_burst_addr #(
    .ADDR_W (ADDR_W)
  ) u_stage2Addr (
    .op     (stage2),
    .addr   (s2Addr)
  );

  // ****************************************************************
  // pipeline
  // ****************************************************************
  always_comb begin
    next_stage1 = stage1;
    next_stage2 = stage2;
    if (!awake) begin
      // pending work may be lost; controller must drain first
      next_stage1 = sssp_pkg::OP_IDLE;
      next_stage2 = sssp_pkg::OP_IDLE;
    end else if (accept) begin
      // stage 1: command or burst advance
      if (!cmd.advanceLoadN) begin
        next_stage1 = sssp_pkg::OP_IDLE;
        if (selected) begin
          next_stage1.valid    = 1'h1;
          next_stage1.isWrite  = (cmd.readWriteN == sssp_pkg::RW_WRITE);
          next_stage1.order    = cmd.burstOrder;
          next_stage1.baseAddr = cmd.addr;
        end
      end else if (stage1.valid) begin
        // only the low count wraps; the base stays put
        next_stage1.count = BW'(stage1.count + 1'h1);
      end
      next_stage2 = stage1;
    end
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      stage1 <= sssp_pkg::OP_IDLE;
      stage2 <= sssp_pkg::OP_IDLE;
    end else begin
      stage1 <= next_stage1;
      stage2 <= next_stage2;
    end
  end

  // ****************************************************************
  // write data register
  // ****************************************************************
  // write data trails its address by two accepted edges and waits here
  // one more edge, so a read right behind it is served from this register
  always_comb begin
    next_wrAddr = wrAddr;
    next_wrData = wrData;
    next_wrPend = wrPend;
    if (accept) begin
      next_wrPend = stage2.valid && stage2.isWrite;
      if (stage2.valid && stage2.isWrite) begin
        next_wrAddr = s2Addr;
        next_wrData = dataIn;
      end
    end
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      wrAddr <= '0;
      wrData <= '0;
      wrPend <= 1'h0;
    end else begin
      wrAddr <= next_wrAddr;
      wrData <= next_wrData;
      wrPend <= next_wrPend;
    end
  end

  // ****************************************************************
  // read output
  // ****************************************************************
  always_comb begin
    next_dataOut       = dataOut;
    next_dataOutEnable = dataOutEnable;
    if (!awake) begin
      next_dataOutEnable = 1'h0;
    end else if (accept) begin
      next_dataOutEnable = stage2.valid && !stage2.isWrite;
      if (stage2.valid && !stage2.isWrite) begin
        if (wrPend && wrAddr == s2Addr) begin
          next_dataOut = wrData;
        end else begin
          next_dataOut = mem[s2Addr];
        end
      end
    end
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      dataOut       <= '0;
      dataOutEnable <= 1'h0;
    end else begin
      dataOut       <= next_dataOut;
      dataOutEnable <= next_dataOutEnable;
    end
  end

  // ****************************************************************
  // sleep flag
  // ****************************************************************
  always_comb begin
    next_sleepSeen = sleepRequest;
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      sleepSeen <= 1'h0;
    end else begin
      sleepSeen <= next_sleepSeen;
    end
  end

  assign asleep = sleepSeen;

  // ****************************************************************
  // array
  // ****************************************************************
  // array write: only on an enabled, awake edge, so a stall loses nothing
  always_ff @(posedge clk_sys) begin
    if (accept && wrPend) begin
      mem[wrAddr] <= wrData;
    end
  end

endmodule

// ****************************************************************
// burst address: linear adds the count, interleaved xors it
// ****************************************************************
module sssp_burst_addr #(
  parameter int ADDR_W = sssp_pkg::ADDR_W
) (
  input  wire sssp_pkg::sssp_op_s op,
  output logic [ADDR_W-1:0]       addr
);

  localparam int BW = sssp_pkg::BURST_W;

  // the operation carrier fixes the address width
  if (ADDR_W != sssp_pkg::ADDR_W || ADDR_W <= BW) begin : g_badWidth
    $error("sssp_burst_addr: unsupported address width");
  end

  logic [BW-1:0] low;

  always_comb begin
    low = op.baseAddr[BW-1:0];
    if (op.order == sssp_pkg::ORDER_INTERLEAVED) begin
      low = op.baseAddr[BW-1:0] ^ op.count;
    end else begin
      low = op.baseAddr[BW-1:0] + op.count;
    end
    addr = {op.baseAddr[ADDR_W-1:BW], low};
  end

endmodule

// ---- sim/sssp_sram_chk.sv ----
`timescale 1ns/1ps
module sssp_sram_chk #(
  parameter int DATA_W = sssp_pkg::DATA_W
) (
  input wire logic                clk_sys,
  input wire logic                rst,
  input wire logic                sleepRequest,
  input wire logic                clockEnableN,
  input wire sssp_pkg::sssp_cmd_s cmd,
  input wire logic [DATA_W-1:0]   dataOut,
  input wire logic                dataOutEnable,
  input wire logic                asleep
);
  default clocking dc @(posedge clk_sys); endclocking
  default disable iff (rst);
  wire acc = !clockEnableN && !sleepRequest;
  wire sel = !cmd.chipSelectLowA && !cmd.chipSelectLowB && cmd.chipSelectHigh;
  wire ld  = !cmd.advanceLoadN;
  property p_rd; (acc && ld && sel && cmd.readWriteN) ##1 acc ##1 acc |=> dataOutEnable; endproperty
  a_rd: assert property (p_rd) else $error("read not answered");
  property p_desel; (acc && ld && !sel) ##1 acc ##1 acc |=> !dataOutEnable; endproperty
  a_desel: assert property (p_desel) else $error("deselected cycle drove data");
  property p_zzld; (sleepRequest && ld && sel) ##1 acc ##1 acc |=> !dataOutEnable; endproperty
  a_zzld: assert property (p_zzld) else $error("load taken while asleep");
  property p_zz; sleepRequest |=> !dataOutEnable; endproperty
  a_zz: assert property (p_zz) else $error("output driven while asleep");
  property p_rise; $rose(sleepRequest) |=> asleep && !dataOutEnable; endproperty
  a_rise: assert property (p_rise) else $error("sleep entry late");
  property p_fell; $fell(sleepRequest) |=> !asleep; endproperty
  a_fell: assert property (p_fell) else $error("sleep exit late");
  property p_hold; (clockEnableN && !sleepRequest) |=> $stable(dataOut) && $stable(dataOutEnable);
  endproperty
  a_hold: assert property (p_hold) else $error("stall edge moved outputs");
  property p_slp; sleepRequest [*2] |-> asleep && !dataOutEnable; endproperty
  a_slp: assert property (p_slp) else $error("device awake during sleep");
  c_rd: cover property (acc && ld && sel && cmd.readWriteN);
  c_stall: cover property (clockEnableN && dataOutEnable);
  c_zz: cover property ($fell(sleepRequest));
endmodule
bind sssp_sram sssp_sram_chk #(.DATA_W(DATA_W)) u_chk (.clk_sys(clk_sys), .rst(rst),
  .sleepRequest(sleepRequest), .clockEnableN(clockEnableN), .cmd(cmd), .dataOut(dataOut),
  .dataOutEnable(dataOutEnable), .asleep(asleep));

// ---- sim/sssp_ctl.sv ----
`timescale 1ns/1ps
// ****
// controller: all three selects set whole at each load
// ****
module sssp_ctl (
  input  wire logic                   clk_sys,
  output sssp_pkg::sssp_cmd_s         cmd,
  output logic [sssp_pkg::DATA_W-1:0] dataIn,
  output logic                        clockEnableN,
  output logic                        sleepRequest
);
  logic [sssp_pkg::DATA_W-1:0] wd, p1;
  initial {sleepRequest, clockEnableN, cmd, dataIn, p1} = {16'h3200, 36'h0};
  task cyc(input logic [15:0] c, input logic [17:0] d);
    @(posedge clk_sys);
    {sleepRequest, clockEnableN, cmd} <= c;
    wd <= d;
  endtask
  // data lags its load by two accepted edges; idle bus toggles so stale data is not reused
  always @(posedge clk_sys) if (!clockEnableN && !sleepRequest) begin
    p1 <= (!cmd.advanceLoadN && !cmd.readWriteN) ? wd : ~p1;
    dataIn <= p1;
  end
endmodule

// ---- sim/sync_sram_snooze_pipeline_tb.sv ----
`timescale 1ns/1ps
module sync_sram_snooze_pipeline_tb;
  localparam logic [15:0] idle = 16'h3200;
  logic clk_sys = 1'b0, rst = 1'b1, zzLast = 1'b0;
  int   failCount = 0, totalChecks = 0;
  wire sssp_pkg::sssp_cmd_s cmd;
  wire logic [17:0] dataIn, dataOut;
  wire logic        dataOutEnable, asleep, sleepRequest, clockEnableN;
  sssp_ctl CTL (.clk_sys(clk_sys), .cmd(cmd), .dataIn(dataIn), .clockEnableN(clockEnableN),
    .sleepRequest(sleepRequest));
  sssp_sram DUT (.clk_sys(clk_sys), .rst(rst), .sleepRequest(sleepRequest),
    .clockEnableN(clockEnableN), .cmd(cmd), .dataIn(dataIn), .dataOut(dataOut),
    .dataOutEnable(dataOutEnable), .asleep(asleep));
  initial forever #4 clk_sys = ~clk_sys;
  function automatic logic [15:0] R(input logic [7:0] a); return {8'h0a, a}; endfunction
  task automatic chk(input logic [19:0] got, input logic [19:0] exp);
    totalChecks++;
    if (got !== exp) begin
      failCount++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // each step checks the answer to the command issued three steps earlier, four when a stalled step lies between
  task automatic s(input logic [15:0] c, input logic [17:0] d, input logic [18:0] e);
    CTL.cyc(c, d);
    #1 chk({asleep, dataOutEnable, e[18] ? dataOut : 18'h0}, {zzLast, e});
    zzLast = c[15];
  endtask
  task automatic fwd();
    s({8'h08, 8'h10}, 18'h11111, 19'h0);
    s(R(8'h10), 18'h0, 19'h0);
    s({8'h08, 8'h10}, 18'h22222, 19'h0);
    s(R(8'h10), 18'h0, 19'h0);
    s(idle, 18'h0, {1'b1, 18'h11111});
    s(idle, 18'h0, 19'h0);
    s(idle, 18'h0, {1'b1, 18'h22222});
  endtask
  task automatic stall();
    s(R(8'h10), 18'h0, 19'h0);
    s({8'h48, 8'h10}, 18'h33333, 19'h0);
    s(idle, 18'h0, 19'h0);
    s(idle, 18'h0, 19'h0);
    s(idle, 18'h0, {1'b1, 18'h22222});
    s(R(8'h10), 18'h0, 19'h0);
    s(idle, 18'h0, 19'h0);
    s(idle, 18'h0, 19'h0);
    s({8'h48, 8'h10}, 18'h0, {1'b1, 18'h22222});
    s(idle, 18'h0, {1'b1, 18'h22222});
  endtask
  task automatic burst(input logic o);
    logic [1:0] j;
    for (int i = 0; i < 4; i++) s({8'h08, 6'h08, 2'(i)}, {10'h2a5, 6'h08, 2'(i)}, 19'h0);
    for (int i = 0; i < 7; i++) begin
      j = o ? (2'h1 ^ 2'(i - 3)) : (2'h1 + 2'(i - 3));
      s(i == 0 ? {7'h05, o, 8'h21} : (i < 4 ? {7'h07, o, 8'h21} : idle), 18'h0,
        i < 3 ? 19'h0 : {1'b1, 10'h2a5, 6'h08, j});
    end
  endtask
  task automatic sel();
    for (int i = 0; i < 11; i++)
      s(i < 8 ? {2'h0, 3'(i), 11'h210} : idle, 18'h0, i == 4 ? {1'b1, 18'h22222} : 19'h0);
  endtask
  task automatic snooze();
    s({8'h88, 8'h10}, 18'h3ffff, 19'h0);
    s({8'h8a, 8'h10}, 18'h0, 19'h0);
    s({8'h8a, 8'h10}, 18'h0, 19'h0);
    s(R(8'h10), 18'h0, 19'h0);
    s(idle, 18'h0, 19'h0);
    s(idle, 18'h0, 19'h0);
    s(idle, 18'h0, {1'b1, 18'h22222});
  endtask
  task summarize();
    $display("checks %0d mismatches %0d", totalChecks, failCount);
    if (failCount == 0 && totalChecks > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  initial begin
    repeat (6) @(posedge clk_sys);
    rst <= 1'b0;
    fwd();
    stall();
    burst(1'b0);
    burst(1'b1);
    sel();
    snooze();
    summarize();
  end
endmodule
